// *** design/kplf_keypad_flags.sv ***
// keypad line flag logic: level detect, read-to-clear flags, enables and interrupt
//
// Functional notes
// - eight line flags set on programmed level
// - flag raises request only when enabled
// - flag register ignores bus writes
// - reading flags returns them, then clears all whose line is off its level
// - enable zero leaves pin plain I/O
// - enable one lets flag request interrupt
// - flags and enables reset to zero
// - polarity bit: zero low, one high
// - global enable gates combined keypad request
// - one shared request, also wakes processor
//
// register map (byte registers on the plain register port)
//   0x9C level polarity select, one bit per line
//        bit clear: the line matches while low
//        bit set:   the line matches while high
//        resets to all zeros, so every line starts as low-level detect
//   0x9D line irq enables, one bit per line
//        bit clear: the pin stays plain I/O, its flag raises nothing
//        bit set:   the line's flag feeds the shared keypad request
//        also shown on keypad_mode so port muxing can follow it
//   0x9E line hit flags, read to clear
//        a flag sets while its line shows the programmed level
//        writes are dropped, software clears only by reading
//        a line still at its level at the read edge sets again
//   0xA0 keypad global irq enable, bit 0
//        gates the shared request toward the interrupt controller
//        the wake path is not gated by it
//   0xA1 sticky status, write one to clear
//        bit 0: an enabled line showed its level
//        bit 1: the ungated shared request rose
//        a new event in the clearing cycle wins over the clear
//   0xA2 status mask, same layout as the status register
//   other addresses read as zero and ignore writes
//
// timing
//   a line level seen at edge n shows in its flag after edge n
//   the request outputs follow the flag and enable registers
//   combinationally, so they move in the same cycle as the flags
//   read data stands for exactly the cycle after the read strobe
//   and is zero in every other cycle
//   level detection is not filtered: a bouncing key simply
//   re-sets its flag, which is harmless for a sticky flag
//   inputs are taken as already synchronous to the core clock
//   software that leaves a key held will see its flag come back
//   right after each read, so the request stays up until release
`timescale 1ns/100ps
`include "kplf_regs.svh"

module kplf_keypad_flags
    import kplf_pkg::*;
#(
    parameter int LINES = 8                    // keypad line count
) (
    input  wire logic               clock,      // core clock
    input  wire logic               reset,      // synchronous, active high
    input  wire logic [LINES-1:0]   line_in,    // port line levels
    input  wire kplf_addr_t         reg_addr,   // register address
    input  wire kplf_byte_t         reg_wdata,  // write data
    input  wire logic               reg_write,  // write strobe
    input  wire logic               reg_read,   // read strobe
    output kplf_byte_t              reg_rdata,  // read data, one cycle later
    output logic [LINES-1:0]        keypad_mode,        // line used as keypad source
    output logic                    keypad_irq_request, // gated shared request
    output logic                    wake_request,       // wake from idle/power-down
    output logic                    irq                 // sticky status interrupt
);

    // register state
    logic [LINES-1:0]           flags_q, flags_d;        // line hit flags
    logic [LINES-1:0]           enables_q, enables_d;    // line irq enables
    logic [LINES-1:0]           polarity_q, polarity_d;  // level polarity select
    logic                       global_q, global_d;      // keypad global irq enable
    logic [`KPLF_ST_WIDTH-1:0]  status_q, status_d;      // sticky events
    logic [`KPLF_ST_WIDTH-1:0]  mask_q, mask_d;          // status mask
    kplf_byte_t                 rdata_q, rdata_d;        // read data register
    logic                       req_q;                   // registered request

    // per-line match and gated flag
    logic [LINES-1:0]           match;       // line shows its programmed level
    logic [LINES-1:0]           gated;       // flag and enable
    logic                       comb_req;    // OR of gated flags
    logic                       flag_read;   // read of the flag register
    logic [`KPLF_ST_WIDTH-1:0]  ev;          // status events

    // per-line level detection and gating
    genvar g;
    generate
        for (g = 0; g < LINES; g++) begin : g_line
            assign match[g] = (line_in[g] == polarity_q[g]);
            assign gated[g] = flags_q[g] & enables_q[g];
        end
    endgenerate

    assign comb_req  = |gated;
    assign flag_read = reg_read && (reg_addr == `KPLF_OFF_FLAGS);
    assign ev[`KPLF_ST_HIT_BIT]  = |(match & enables_q);
    assign ev[`KPLF_ST_WAKE_BIT] = comb_req & ~req_q;

    // next-state of all registers except req_q
    always_comb begin
        flags_d    = flags_q;
        enables_d  = enables_q;
        polarity_d = polarity_q;
        global_d   = global_q;
        status_d   = status_q;
        mask_d     = mask_q;
        rdata_d    = '0;
        // read of flags clears them; a new match in that cycle still sets
        if (flag_read) begin
            flags_d = '0;
        end
        flags_d = flags_d | match;
        if (reg_write) begin
            unique case (reg_addr)
                `KPLF_OFF_POLARITY: polarity_d = reg_wdata[LINES-1:0];
                `KPLF_OFF_ENABLES:  enables_d  = reg_wdata[LINES-1:0];
                `KPLF_OFF_GLOBAL:   global_d   = reg_wdata[`KPLF_GLOBAL_EN_BIT];
                `KPLF_OFF_STATUS:   status_d   = status_q & ~reg_wdata[`KPLF_ST_WIDTH-1:0];
                `KPLF_OFF_MASK:     mask_d     = reg_wdata[`KPLF_ST_WIDTH-1:0];
                default: ;          // flags and unmapped: no effect
            endcase
        end
        status_d = status_d | ev;   // set wins over clear
        if (reg_read) begin
            unique case (reg_addr)
                `KPLF_OFF_POLARITY: rdata_d = kplf_byte_t'(polarity_q);
                `KPLF_OFF_ENABLES:  rdata_d = kplf_byte_t'(enables_q);
                `KPLF_OFF_FLAGS:    rdata_d = kplf_byte_t'(flags_q);
                `KPLF_OFF_GLOBAL:   rdata_d = kplf_byte_t'(global_q);
                `KPLF_OFF_STATUS:   rdata_d = kplf_byte_t'(status_q);
                `KPLF_OFF_MASK:     rdata_d = kplf_byte_t'(mask_q);
                default:            rdata_d = '0;   // unmapped reads zero
            endcase
        end
    end

    // register all state
    always_ff @(posedge clock) begin
        if (reset) begin
            flags_q    <= '0;
            enables_q  <= '0;
            polarity_q <= '0;
            global_q   <= 1'b0;
            status_q   <= '0;
            mask_q     <= '0;
            rdata_q    <= '0;
            req_q      <= 1'b0;
        end else begin
            flags_q    <= flags_d;
            enables_q  <= enables_d;
            polarity_q <= polarity_d;
            global_q   <= global_d;
            status_q   <= status_d;
            mask_q     <= mask_d;
            rdata_q    <= rdata_d;
            req_q      <= comb_req;
        end
    end

    // outputs
    // read data and mode come straight from flip-flops; the request
    // outputs are combinational from registers only, so they carry
    // no path from the bus or the pins within one cycle
    assign reg_rdata          = rdata_q;
    assign keypad_mode        = enables_q;
    assign keypad_irq_request = comb_req & global_q;
    assign wake_request       = comb_req;
    assign irq                = |(status_q & mask_q);

    // checks
    AST_SET: assert property (@(posedge clock) disable iff (reset)
        (match[0] && !reset) |=> flags_q[0])
        else $error("matched line 0 did not set its flag");
    AST_GATE: assert property (@(posedge clock) disable iff (reset)
        keypad_irq_request |-> |(flags_q & enables_q))
        else $error("request without enabled flag");
    AST_WRITE_NOP: assert property (@(posedge clock) disable iff (reset)
        (reg_write && reg_addr == `KPLF_OFF_FLAGS && !reg_read && ~|match)
        |=> flags_q == $past(flags_q))
        else $error("write changed flags");
    AST_RDCLR: assert property (@(posedge clock) disable iff (reset)
        flag_read |=> (reg_rdata == kplf_byte_t'($past(flags_q)))
                      && (flags_q == $past(match)))
        else $error("flag read did not return and clear");
    AST_MODE: assert property (@(posedge clock) disable iff (reset)
        keypad_mode == enables_q)
        else $error("keypad mode differs from enables");
    AST_ENABLE: assert property (@(posedge clock) disable iff (reset)
        (global_q && |(flags_q & enables_q)) |-> keypad_irq_request)
        else $error("enabled flag did not raise request");
    AST_RESET: assert property (@(posedge clock)
        reset |=> (flags_q == '0) && (enables_q == '0) && (polarity_q == '0))
        else $error("reset values wrong");
    AST_GLOBAL: assert property (@(posedge clock) disable iff (reset)
        !global_q |-> !keypad_irq_request)
        else $error("request passed with global enable off");
    AST_OR: assert property (@(posedge clock) disable iff (reset)
        wake_request == |(flags_q & enables_q))
        else $error("combined request not OR of gated flags");

    COV_HIT: cover property (@(posedge clock) disable iff (reset)
        keypad_irq_request ##1 flag_read ##1 !keypad_irq_request);
    COV_HIGH: cover property (@(posedge clock) disable iff (reset)
        polarity_q[0] && match[0]);
    COV_IRQ: cover property (@(posedge clock) disable iff (reset) irq);
    COV_RD_SET: cover property (@(posedge clock) disable iff (reset)
        flag_read && |match);
    COV_DISABLED: cover property (@(posedge clock) disable iff (reset)
        |flags_q && ~|enables_q);

    // further checks
    // line 0 stands for every line: the generate loop makes them alike,
    // so a fault in the per-line logic shows on line 0 as well
    // checks on the bus side look one edge after the strobe, where the
    // register has taken the new value

    AST_POL_HIGH: assert property (@(posedge clock) disable iff (reset)
        (polarity_q[0] && line_in[0]) |=> flags_q[0])
        else $error("high level on high-detect line did not set flag");

    AST_POL_LOW: assert property (@(posedge clock) disable iff (reset)
        (!polarity_q[0] && !line_in[0]) |=> flags_q[0])
        else $error("low level on low-detect line did not set flag");

    AST_NO_SET: assert property (@(posedge clock) disable iff (reset)
        (!match[0] && flag_read) |=> !flags_q[0])
        else $error("flag set without its level");

    AST_HOLD: assert property (@(posedge clock) disable iff (reset)
        (!flag_read && flags_q[0]) |=> flags_q[0])
        else $error("flag lost without a read");

    AST_EN_WRITE: assert property (@(posedge clock) disable iff (reset)
        (reg_write && reg_addr == `KPLF_OFF_ENABLES)
        |=> enables_q == $past(reg_wdata[LINES-1:0]))
        else $error("enable write did not land");

    AST_DISABLED: assert property (@(posedge clock) disable iff (reset)
        (enables_q == '0) |-> !wake_request)
        else $error("request with every line plain I/O");

    AST_DIS_FLAG: assert property (@(posedge clock) disable iff (reset)
        (|flags_q && enables_q == '0) |-> !keypad_irq_request)
        else $error("disabled flag raised request");

    AST_GLOBAL_WRITE: assert property (@(posedge clock) disable iff (reset)
        (reg_write && reg_addr == `KPLF_OFF_GLOBAL)
        |=> global_q == $past(reg_wdata[`KPLF_GLOBAL_EN_BIT]))
        else $error("global enable write did not land");

    AST_RDATA_IDLE: assert property (@(posedge clock) disable iff (reset)
        !reg_read |=> reg_rdata == 8'h00)
        else $error("read data outside its cycle");

    AST_STATUS_SET: assert property (@(posedge clock) disable iff (reset)
        (|(match & enables_q)) |=> status_q[`KPLF_ST_HIT_BIT])
        else $error("enabled match did not set status");

    AST_WAKE_EDGE: assert property (@(posedge clock) disable iff (reset)
        (comb_req && !req_q) |=> status_q[`KPLF_ST_WAKE_BIT])
        else $error("request rise did not set status");

    AST_MASK_OFF: assert property (@(posedge clock) disable iff (reset)
        (mask_q == '0) |-> !irq)
        else $error("interrupt with mask clear");

    AST_POL_WRITE: assert property (@(posedge clock) disable iff (reset)
        (reg_write && reg_addr == `KPLF_OFF_POLARITY)
        |=> polarity_q == $past(reg_wdata[LINES-1:0]))
        else $error("polarity write did not land");

endmodule : kplf_keypad_flags

// *** design/kplf_pkg.sv ***
// types shared by the keypad line flag block
package kplf_pkg;
    typedef logic [7:0] kplf_byte_t;   // one register byte
    typedef logic [7:0] kplf_addr_t;   // register address
endpackage : kplf_pkg

// *** design/kplf_regs.svh ***
// register offsets, reset values and field layout of the keypad line flag block
`ifndef KPLF_REGS_SVH
`define KPLF_REGS_SVH
`define KPLF_OFF_POLARITY   8'h9C
`define KPLF_OFF_ENABLES    8'h9D
`define KPLF_OFF_FLAGS      8'h9E
`define KPLF_OFF_GLOBAL     8'hA0
`define KPLF_OFF_STATUS     8'hA1
`define KPLF_OFF_MASK       8'hA2
`define KPLF_RST_BYTE       8'h00
`define KPLF_GLOBAL_EN_BIT  0
`define KPLF_ST_HIT_BIT     0
`define KPLF_ST_WAKE_BIT    1
`define KPLF_ST_WIDTH       2
`endif

// *** test/kplf_keypad_model.sv ***
// keypad partner model: pressed keys pull lines low, released lines float high
`timescale 1ns/100ps
module kplf_keypad_model (
    input  wire logic [7:0] press,    // one bit per pressed key
    output logic      [7:0] line_out  // port line levels seen by the block
);
    // pull-up holds released lines high, a pressed key shorts its line low
    assign line_out = ~press;
endmodule : kplf_keypad_model

// *** test/tb_kplf_keypad_flags.sv ***
// self-checking bench for the keypad line flag block
`timescale 1ns/100ps
`include "kplf_regs.svh"
module tb_kplf_keypad_flags
    import kplf_pkg::*;
;
    logic       clock = 1'b0;     // core clock
    logic       reset = 1'b1;     // synchronous reset
    logic       reg_write = 1'b0; // write strobe
    logic       reg_read = 1'b0;  // read strobe
    kplf_addr_t reg_addr = 8'h00; // register address
    kplf_byte_t reg_wdata = 8'h00;
    kplf_byte_t reg_rdata;        // read data
    kplf_byte_t mode;             // keypad source lines
    logic       req;              // gated keypad request
    logic       wake;             // ungated request
    logic       irq;              // status interrupt
    logic [7:0] press = 8'h00;    // keys held down
    logic [7:0] line_in;          // line levels
    int         failures = 0;
    int         compares = 0;
    int         cycles = 0;

    kplf_keypad_model pad (.press(press), .line_out(line_in));
    kplf_keypad_flags #(.LINES(8)) uut (.clock(clock), .reset(reset), .line_in(line_in),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .keypad_mode(mode),
        .keypad_irq_request(req), .wake_request(wake), .irq(irq));

    always #4 clock = ~clock;

    // hang guard: the sequence needs well under 200 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            give_verdict();
        end
    end

    task automatic chk(input kplf_byte_t got, input kplf_byte_t exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one-cycle write, returns once the register has updated
    task automatic wr(input kplf_addr_t a, input kplf_byte_t d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        #1;
    endtask : wr

    // one-cycle read, data compared in the following cycle
    task automatic rd(input kplf_addr_t a, input kplf_byte_t exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd

    // change held keys and let the flags settle
    task automatic keys(input logic [7:0] p);
        @(posedge clock);
        press <= p;
        repeat (2) @(posedge clock);
        #1;
    endtask : keys

    task automatic give_verdict();
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    initial begin
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        #1 chk(mode, 8'h00);
        rd(`KPLF_OFF_ENABLES, 8'h00);
        rd(`KPLF_OFF_FLAGS, 8'h00);
        wr(`KPLF_OFF_GLOBAL, 8'h01);
        keys(8'h04);
        chk({7'h00, req}, 8'h00);
        keys(8'h00);
        rd(`KPLF_OFF_FLAGS, 8'h04);
        rd(`KPLF_OFF_FLAGS, 8'h00);
        keys(8'h02);
        wr(`KPLF_OFF_FLAGS, 8'hFF);
        rd(`KPLF_OFF_FLAGS, 8'h02);
        wr(`KPLF_OFF_ENABLES, 8'h04);
        wr(`KPLF_OFF_MASK, 8'h01);
        chk(mode, 8'h04);
        keys(8'h84);
        chk({irq, req}, 8'h03);
        keys(8'h00);
        chk({7'h00, req}, 8'h01);
        wr(`KPLF_OFF_GLOBAL, 8'h00);
        chk({wake, req}, 8'h02);
        rd(`KPLF_OFF_FLAGS, 8'h86);
        chk({7'h00, wake}, 8'h00);
        wr(`KPLF_OFF_MASK, 8'h00);
        chk({7'h00, irq}, 8'h00);
        wr(`KPLF_OFF_MASK, 8'h01);
        wr(`KPLF_OFF_STATUS, 8'h03);
        chk({7'h00, irq}, 8'h00);
        wr(`KPLF_OFF_POLARITY, 8'h01);
        wr(`KPLF_OFF_POLARITY, 8'h00);
        rd(`KPLF_OFF_FLAGS, 8'h01);
        rd(`KPLF_OFF_FLAGS, 8'h00);
        rd(8'hB0, 8'h00);
        give_verdict();
    end
endmodule : tb_kplf_keypad_flags
